// [logic/bfm_channel.sv]
module bfm_channel
    import bfm_pkg::*;
#(
    parameter int DLY_W = 16
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    // firing control
    input  wire logic             active_in,
    input  wire logic             start_in,
    input  wire logic             cw_in,
    input  wire logic             invert_in,
    input  wire logic [DLY_W-1:0] delay_in,
    input  wire logic [6:0]       div_in,
    input  wire logic [6:0]       len_in,
    input  wire logic [63:0]      p_pat_in,
    input  wire logic [63:0]      n_pat_in,
    // pulser drive
    output logic                  p_out,
    output logic                  n_out,
    output logic                  firing_out
);
    typedef enum logic [1:0] {
        CH_IDLE  = 2'b00,
        CH_COUNT = 2'b01,
        CH_FIRE  = 2'b11,
        CH_DONE  = 2'b10
    } bfm_ch_state_type;

    typedef struct packed {
        bfm_ch_state_type fsm;
        logic [DLY_W-1:0] cnt;
        logic [6:0]       wcnt;
        logic [5:0]       idx;
        logic             p;
        logic             n;
    } bfm_ch_type;

    bfm_ch_type st;
    bfm_ch_type next_st;
    logic [6:0] unit;
    logic       last;
    logic       go;
    logic [5:0] step;

    always_comb begin
        next_st = st;
        // divider of zero is served as one
        unit = (div_in == 7'h00) ? 7'h00 : div_in - 7'h01;
        last = ({1'b0, st.idx} >= len_in - 7'h01);
        step = last ? 6'h00 : st.idx + 6'h01;
        go = (st.fsm == CH_IDLE && start_in && delay_in == '0) ||
             (st.fsm == CH_COUNT && st.cnt == '0);
        case (st.fsm)
            CH_IDLE: begin
                if (start_in && delay_in != '0) begin
                    next_st.fsm = CH_COUNT;
                    next_st.cnt = delay_in - 1'b1;
                end
            end
            CH_COUNT: begin
                if (st.cnt != '0) begin
                    next_st.cnt = st.cnt - 1'b1;
                end
            end
            CH_FIRE: begin
                if (st.wcnt != 7'h00) begin
                    next_st.wcnt = st.wcnt - 7'h01;
                end else if (last && !cw_in) begin
                    next_st.fsm = CH_DONE;
                    next_st.p = 1'b0;
                    next_st.n = 1'b0;
                end else begin
                    // wrap to bit 0 with no gap in continuous wave
                    next_st.idx = step;
                    next_st.wcnt = unit;
                    next_st.p = p_pat_in[step] ^ invert_in;
                    next_st.n = n_pat_in[step] ^ invert_in;
                end
            end
            default: begin
            end
        endcase
        if (go) begin
            next_st.fsm = CH_FIRE;
            next_st.idx = 6'h00;
            next_st.wcnt = unit;
            next_st.p = p_pat_in[0] ^ invert_in;
            next_st.n = n_pat_in[0] ^ invert_in;
        end
        if (!active_in) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign p_out      = st.p;
    assign n_out      = st.n;
    assign firing_out = (st.fsm == CH_FIRE);

    AST_LSB_FIRST: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        go && active_in |=> st.idx == 6'h00 && st.fsm == CH_FIRE)
        else $error("firing did not begin at bit zero");

    AST_CW_WRAP: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        st.fsm == CH_FIRE && cw_in && active_in |=> st.fsm == CH_FIRE)
        else $error("continuous wave train stopped");

    AST_BIT_WIDTH: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        st.fsm == CH_FIRE && $changed(st.idx) |-> $past(st.wcnt) == 7'h00)
        else $error("pattern bit advanced before its width ran out");

    AST_LEN_LIMIT: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        st.fsm == CH_FIRE && $stable(len_in) |=>
            st.fsm != CH_FIRE || {1'b0, st.idx} < len_in)
        else $error("bit index passed the selected length");
endmodule

// [logic/bfm_pkg.sv]
package bfm_pkg;
    localparam int BFM_CHANNELS = 8;

    // register addresses on the serial link
    localparam logic [4:0] BFM_ADDR_DELAY_LAST = 5'h07;
    localparam logic [4:0] BFM_ADDR_P_PATTERN  = 5'h18;
    localparam logic [4:0] BFM_ADDR_N_PATTERN  = 5'h19;
    localparam logic [4:0] BFM_ADDR_CONTROL    = 5'h1A;
    localparam logic [4:0] BFM_ADDR_STATUS     = 5'h1B;

    // serial frame: read bit, five address bits, then data
    localparam logic [6:0] BFM_HDR_BITS  = 7'h06;
    localparam logic [6:0] BFM_DATA_BITS = 7'h40;

    localparam int BFM_DELAY_BITS = 22;
    localparam int BFM_PAT_BITS   = 64;
    localparam int BFM_CTRL_BITS  = 13;

    // control word fields (reserved bit 13 is never stored)
    localparam int BFM_CTRL_CW      = 12;
    localparam int BFM_CTRL_INV     = 11;
    localparam int BFM_CTRL_PLL     = 10;
    localparam int BFM_CTRL_DIV_MSB = 9;
    localparam int BFM_CTRL_DIV_LSB = 3;
    localparam int BFM_CTRL_LEN_MSB = 2;
    localparam int BFM_CTRL_LEN_LSB = 0;

    // status word fields
    localparam int BFM_STAT_TX     = 0;
    localparam int BFM_STAT_INVERT = 1;
    localparam int BFM_STAT_PHASE  = 2;
    localparam int BFM_STAT_FIRING = 3;

    localparam logic [12:0] BFM_CTRL_RESET  = 13'h0000;
    localparam logic [21:0] BFM_DELAY_RESET = 22'h00_0000;
    localparam logic [63:0] BFM_PAT_RESET   = 64'h0000_0000_0000_0000;

    // fixed continuous-wave patterns, sent lsb first
    localparam logic [63:0] BFM_CW_P = 64'h5555_5555_5555_5555;
    localparam logic [63:0] BFM_CW_N = 64'hAAAA_AAAA_AAAA_AAAA;

    // fast-clock cycles from enable edge to delay count start
    localparam logic [2:0] BFM_START_CYCLES = 3'h6;

    function automatic logic [6:0] bfm_len_bits(input logic [2:0] code);
        case (code)
            3'h0:    bfm_len_bits = 7'h04;
            3'h1:    bfm_len_bits = 7'h08;
            3'h2:    bfm_len_bits = 7'h10;
            3'h3:    bfm_len_bits = 7'h20;
            default: bfm_len_bits = 7'h40;
        endcase
    endfunction

    function automatic logic bfm_is_delay(input logic [4:0] addr);
        bfm_is_delay = (addr <= BFM_ADDR_DELAY_LAST);
    endfunction
endpackage

// [logic/bfm_serial.sv]
module bfm_serial
    import bfm_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    // pins
    input  wire logic        ser_clk_in,
    input  wire logic        ser_data_in,
    input  wire logic        ser_en_in,
    output logic             ser_dout_out,
    // register side
    input  wire logic [63:0] rd_data_in,
    output logic             wr_out,
    output logic [4:0]       addr_out,
    output logic [63:0]      data_out
);
    typedef enum logic {SP_IDLE = 1'b0, SP_SHIFT = 1'b1} bfm_sp_state_type;

    typedef struct packed {
        logic             clk1;
        logic             clk2;
        logic             clk3;
        logic             dat1;
        logic             dat2;
        logic             en1;
        logic             en2;
        bfm_sp_state_type fsm;
        logic [6:0]       cnt;
        logic             rw;
        logic [4:0]       addr;
        logic [63:0]      data;
        logic             wr;
        logic             ld;
        logic [63:0]      rdsh;
        logic             dout;
    } bfm_sp_type;

    bfm_sp_type st;
    bfm_sp_type next_st;
    logic       rise;

    always_comb begin
        next_st = st;
        next_st.clk1 = ser_clk_in;
        next_st.clk2 = st.clk1;
        next_st.clk3 = st.clk2;
        next_st.dat1 = ser_data_in;
        next_st.dat2 = st.dat1;
        next_st.en1 = ser_en_in;
        next_st.en2 = st.en1;
        next_st.wr = 1'b0;
        next_st.ld = 1'b0;
        rise = st.clk2 & ~st.clk3;
        case (st.fsm)
            SP_IDLE: begin
                next_st.dout = 1'b0;
                if (st.en2) begin
                    next_st.fsm = SP_SHIFT;
                    next_st.cnt = 7'h00;
                    next_st.rw = 1'b0;
                    next_st.addr = 5'h00;
                    next_st.data = '0;
                end
            end
            default: begin
                if (!st.en2) begin
                    next_st.fsm = SP_IDLE;
                    next_st.wr = !st.rw && (st.cnt > BFM_HDR_BITS);
                end else if (rise &&
                             st.cnt < BFM_HDR_BITS + BFM_DATA_BITS) begin
                    // every field arrives lsb first
                    if (st.cnt == 7'h00) begin
                        next_st.rw = st.dat2;
                    end else if (st.cnt < BFM_HDR_BITS) begin
                        next_st.addr[3'(st.cnt - 7'h01)] = st.dat2;
                    end else begin
                        next_st.data[6'(st.cnt - BFM_HDR_BITS)] = st.dat2;
                    end
                    next_st.cnt = st.cnt + 7'h01;
                    if (st.cnt == BFM_HDR_BITS - 7'h01 && st.rw) begin
                        next_st.ld = 1'b1;
                    end
                    if (st.cnt >= BFM_HDR_BITS && st.rw) begin
                        next_st.rdsh = {1'b0, st.rdsh[63:1]};
                        next_st.dout = st.rdsh[1];
                    end
                end
            end
        endcase
        if (st.ld) begin
            next_st.rdsh = rd_data_in;
            next_st.dout = rd_data_in[0];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wr_out       = st.wr;
    assign addr_out     = st.addr;
    assign data_out     = st.data;
    assign ser_dout_out = st.dout;
endmodule

// [logic/bfm_top.sv]
// Behaviour
// - cw mode fires fixed 1-0 / 0-1 patterns
// - pattern registers ignore writes in cw mode
// - cw pattern wraps last bit to first
// - control word: rsvd, cw, inv, pll, div, len
// - control cw bit selects continuous wave firing
// - control invert bit enables invert firing
// - divider field sets unit pulse width
// - length code 0 gives 4, 1 gives 8
// - channel delays kept across firings
// - delay count starts six cycles after enable
// - invert mode alternates plain and inverted firings
// - no alternation unless invert mode enabled
// - pattern goes out lsb toward msb
module bfm_top
    import bfm_pkg::*;
#(
    parameter int CHANNELS = BFM_CHANNELS,
    parameter int DLY_W    = 16
) (
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                rstn_in,
    // firing
    input  wire logic                tx_en_in,
    // serial configuration link
    input  wire logic                ser_clk_in,
    input  wire logic                ser_data_in,
    input  wire logic                ser_en_in,
    output logic                     ser_dout_out,
    // pulser drive
    output logic [CHANNELS-1:0]      pulse_p_out,
    output logic [CHANNELS-1:0]      pulse_n_out,
    output logic                     pll_enable_out
);
    // refused at elaboration, not at run time
    if (CHANNELS < 1 || CHANNELS > BFM_CHANNELS) begin : g_chk_channels
        $error("channel count outside the register map");
    end
    if (DLY_W < 1 || DLY_W > BFM_DELAY_BITS) begin : g_chk_delay
        $error("delay width wider than its register");
    end

    typedef struct packed {
        logic                                    tx1;
        logic                                    tx2;
        logic                                    tx3;
        logic [BFM_CTRL_BITS-1:0]                ctrl;
        logic [BFM_PAT_BITS-1:0]                 ppat;
        logic [BFM_PAT_BITS-1:0]                 npat;
        logic [CHANNELS-1:0][BFM_DELAY_BITS-1:0] delay;
        logic [2:0]                              scnt;
        logic                                    start;
        logic                                    phase;
        logic                                    invert;
    } bfm_top_type;

    bfm_top_type st;
    bfm_top_type next_st;

    // serial port side
    logic        wr;
    logic [4:0]  waddr;
    logic [63:0] wdata;
    logic [63:0] rd_data;
    logic [12:0] ctrl_wr_field;

    // decoded control fields
    logic        cw_en;
    logic        inv_en;
    logic [6:0]  div;
    logic [6:0]  len_bits;
    logic        tx_rise;
    logic [63:0] fire_p;
    logic [63:0] fire_n;
    logic [CHANNELS-1:0] ch_firing;

    assign ctrl_wr_field = wdata[12:0];
    assign cw_en    = st.ctrl[BFM_CTRL_CW];
    assign inv_en   = st.ctrl[BFM_CTRL_INV];
    assign div      = st.ctrl[BFM_CTRL_DIV_MSB:BFM_CTRL_DIV_LSB];
    assign len_bits = bfm_len_bits(
        st.ctrl[BFM_CTRL_LEN_MSB:BFM_CTRL_LEN_LSB]);
    // edge taken from the second and third stages only
    assign tx_rise  = st.tx2 & ~st.tx3;
    // cw ignores the stored patterns but leaves them intact
    assign fire_p   = cw_en ? BFM_CW_P : st.ppat;
    assign fire_n   = cw_en ? BFM_CW_N : st.npat;

    bfm_serial bfm_serial_inst (
        .clk_in       (clk_in),
        .rstn_in      (rstn_in),
        .ser_clk_in   (ser_clk_in),
        .ser_data_in  (ser_data_in),
        .ser_en_in    (ser_en_in),
        .ser_dout_out (ser_dout_out),
        .rd_data_in   (rd_data),
        .wr_out       (wr),
        .addr_out     (waddr),
        .data_out     (wdata)
    );

    // readback mux, addressed while the read header completes
    always_comb begin
        rd_data = '0;
        if (bfm_is_delay(waddr)) begin
            if (32'(waddr) < CHANNELS) begin
                rd_data[BFM_DELAY_BITS-1:0] = st.delay[3'(waddr)];
            end
        end else if (waddr == BFM_ADDR_P_PATTERN) begin
            rd_data = st.ppat;
        end else if (waddr == BFM_ADDR_N_PATTERN) begin
            rd_data = st.npat;
        end else if (waddr == BFM_ADDR_CONTROL) begin
            // reserved bit reads back as zero
            rd_data[BFM_CTRL_BITS-1:0] = st.ctrl;
        end else if (waddr == BFM_ADDR_STATUS) begin
            rd_data[BFM_STAT_TX]     = st.tx2;
            rd_data[BFM_STAT_INVERT] = st.invert;
            rd_data[BFM_STAT_PHASE]  = st.phase;
            rd_data[BFM_STAT_FIRING] = |ch_firing;
        end
    end

    always_comb begin
        next_st = st;
        next_st.tx1 = tx_en_in;
        next_st.tx2 = st.tx1;
        next_st.tx3 = st.tx2;
        next_st.start = 1'b0;

        // register writes; only a write changes a delay
        if (wr) begin
            if (bfm_is_delay(waddr)) begin
                if (32'(waddr) < CHANNELS) begin
                    next_st.delay[3'(waddr)] =
                        wdata[BFM_DELAY_BITS-1:0];
                end
            end else if (waddr == BFM_ADDR_P_PATTERN) begin
                if (!cw_en) begin
                    next_st.ppat = wdata;
                end
            end else if (waddr == BFM_ADDR_N_PATTERN) begin
                if (!cw_en) begin
                    next_st.npat = wdata;
                end
            end else if (waddr == BFM_ADDR_CONTROL) begin
                next_st.ctrl = ctrl_wr_field;
            end
        end

        // start delay after the synchronised enable edge
        if (!st.tx2) begin
            next_st.scnt = 3'h0;
        end else if (tx_rise) begin
            next_st.scnt = BFM_START_CYCLES - 3'h1;
        end else if (st.scnt != 3'h0) begin
            next_st.scnt = st.scnt - 3'h1;
            if (st.scnt == 3'h1) begin
                next_st.start = 1'b1;
                // polarity fixed for the whole firing
                next_st.invert = inv_en & st.phase;
                next_st.phase = inv_en & ~st.phase;
            end
        end

        // leaving invert mode restarts on a plain firing
        if (!inv_en) begin
            next_st.phase = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st <= '{
                tx1:    1'b0,
                tx2:    1'b0,
                tx3:    1'b0,
                ctrl:   BFM_CTRL_RESET,
                ppat:   BFM_PAT_RESET,
                npat:   BFM_PAT_RESET,
                delay:  {CHANNELS{BFM_DELAY_RESET}},
                scnt:   3'h0,
                start:  1'b0,
                phase:  1'b0,
                invert: 1'b0
            };
        end else begin
            st <= next_st;
        end
    end

    generate
        for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
            bfm_channel #(
                .DLY_W (DLY_W)
            ) bfm_channel_inst (
                .clk_in     (clk_in),
                .rstn_in    (rstn_in),
                .active_in  (st.tx2),
                .start_in   (st.start),
                .cw_in      (cw_en),
                .invert_in  (st.invert),
                .delay_in   (st.delay[g][DLY_W-1:0]),
                .div_in     (div),
                .len_in     (len_bits),
                .p_pat_in   (fire_p),
                .n_pat_in   (fire_n),
                .p_out      (pulse_p_out[g]),
                .n_out      (pulse_n_out[g]),
                .firing_out (ch_firing[g])
            );
        end
    endgenerate

    assign pll_enable_out = st.ctrl[BFM_CTRL_PLL];

    AST_START_SIX: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        tx_rise ##1 st.tx2 [*5] |=> st.start)
        else $error("delay count did not start six cycles after enable");

    AST_START_CAUSE: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        st.start |-> $past(st.tx2, 6) && !$past(st.tx3, 6))
        else $error("start without a synchronised enable edge");

    AST_CW_LOCK: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        wr && cw_en && (waddr == BFM_ADDR_P_PATTERN ||
                        waddr == BFM_ADDR_N_PATTERN)
        |=> $stable(st.ppat) && $stable(st.npat))
        else $error("pattern register changed in cw mode");

    AST_CTRL_WRITE: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        wr && waddr == BFM_ADDR_CONTROL
        |=> st.ctrl == $past(ctrl_wr_field))
        else $error("control word not taken");

    AST_INV_FIRST: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        st.scnt == 3'h1 && st.tx2 && inv_en && !st.phase
        |=> st.start && !st.invert ##1 st.phase)
        else $error("invert sequence did not open plain");

    AST_INV_SECOND: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        st.scnt == 3'h1 && st.tx2 && inv_en && st.phase
        |=> st.start && st.invert)
        else $error("second firing not inverted");

    AST_INV_OFF: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        st.start && !$past(inv_en) |-> !st.invert)
        else $error("inverted firing outside invert mode");

    AST_CW_SHAPE: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        ch_firing[0] && cw_en && $past(cw_en) && $past(ch_firing[0])
        |-> pulse_p_out[0] != pulse_n_out[0])
        else $error("cw outputs not complementary");

    AST_DELAY_KEEP: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        !(wr && bfm_is_delay(waddr)) |=> $stable(st.delay))
        else $error("delay changed without a write");

    AST_PAT_WRITE: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        wr && !cw_en && waddr == BFM_ADDR_P_PATTERN
        |=> st.ppat == $past(wdata))
        else $error("pattern write lost outside cw mode");

    // unit width of one clock makes the cw train toggle every cycle
    AST_CW_TOGGLE: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        ch_firing[0] && $past(ch_firing[0]) && cw_en && $past(cw_en) &&
        div <= 7'h01 && $stable(div)
        |-> pulse_p_out[0] != $past(pulse_p_out[0]))
        else $error("cw pulse train not alternating");

    AST_START_PULSE: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        st.start |=> !st.start)
        else $error("start strobe longer than one cycle");

    AST_TX_CLEAR: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        !st.tx2 |=> pulse_p_out == '0 && pulse_n_out == '0)
        else $error("pulser drive left on with enable low");

    AST_INV_HOLD: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        st.scnt != 3'h1 |=> $stable(st.invert))
        else $error("firing polarity changed outside a start");

    AST_PHASE_CLEAR: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        !inv_en |=> !st.phase)
        else $error("invert phase kept outside invert mode");
endmodule

// [verif/bfm_host.sv]
module bfm_host (
    // clock and readback
    input  wire logic clk_in,
    input  wire logic ser_dout_in,
    // serial pins
    output logic      ser_clk_out,
    output logic      ser_data_out,
    output logic      ser_en_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ser_clk_out = 1'b0;
        ser_data_out = 1'b0;
        ser_en_out = 1'b0;
    end

    // four clocks per phase keeps data steady around each rise
    task automatic frame(input logic rd, input logic [4:0] addr,
                         input logic [63:0] wdata, input int nbits,
                         output logic [63:0] rdata);
        logic [69:0] bits;
        int          i;
        bits = {wdata, addr, rd};
        rdata = '0;
        @(negedge clk_in);
        ser_en_out = 1'b1;
        for (i = 0; i < 6 + nbits; i++) begin
            ser_data_out = bits[i];
            repeat (4) @(negedge clk_in);
            if (i >= 6) begin
                rdata[i-6] = ser_dout_in;
            end
            ser_clk_out = 1'b1;
            repeat (4) @(negedge clk_in);
            ser_clk_out = 1'b0;
        end
        ser_en_out = 1'b0;
        // released line must not keep looking valid
        ser_data_out = ~ser_data_out;
        repeat (8) @(negedge clk_in);
    endtask
endmodule

// [verif/bfm_top_tb.sv]
module bfm_top_tb
    import bfm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_in;
    logic        rstn_in;
    logic        tx_en_in;
    logic        ser_clk;
    logic        ser_data;
    logic        ser_en;
    logic        ser_dout;
    logic [7:0]  pulse_p;
    logic [7:0]  pulse_n;
    logic        pll_en;
    logic [7:0]  cap_p [48];
    logic [7:0]  cap_n [48];
    logic [63:0] rdv;
    int          errors;
    int          samples_checked;

    bfm_top bfm_top_inst (
        .clk_in(clk_in), .rstn_in(rstn_in), .tx_en_in(tx_en_in),
        .ser_clk_in(ser_clk), .ser_data_in(ser_data),
        .ser_en_in(ser_en), .ser_dout_out(ser_dout),
        .pulse_p_out(pulse_p), .pulse_n_out(pulse_n),
        .pll_enable_out(pll_en)
    );

    bfm_host bfm_host_inst (
        .clk_in(clk_in), .ser_dout_in(ser_dout), .ser_clk_out(ser_clk),
        .ser_data_out(ser_data), .ser_en_out(ser_en)
    );

    always #4 clk_in = ~clk_in;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [63:0] d, input int n);
        bfm_host_inst.frame(1'b0, a, d, n, rdv);
    endtask

    task automatic rd_chk(input logic [4:0] a, input int n,
                          input logic [63:0] exp);
        bfm_host_inst.frame(1'b1, a, 64'h0, n, rdv);
        check(rdv, exp);
    endtask

    function automatic int first(input int c);
        for (int i = 0; i < 48; i++) begin
            if ((cap_p[i][c] | cap_n[i][c]) === 1'b1) begin
                return i;
            end
        end
        return 40;
    endfunction

    // channel 0 has no delay, channel 1 waits three cycles
    task automatic fire(input logic [7:0] pp, input logic [7:0] pn,
                        input logic inv, input logic cw);
        int         i;
        int         s0;
        logic [1:0] exp;
        @(negedge clk_in);
        tx_en_in = 1'b1;
        for (i = 0; i < 48; i++) begin
            @(negedge clk_in);
            cap_p[i] = pulse_p;
            cap_n[i] = pulse_n;
        end
        tx_en_in = 1'b0;
        repeat (8) @(negedge clk_in);
        s0 = first(0);
        check(64'(s0 >= 7 && s0 <= 10), 64'h1);
        check(64'(first(1) - s0), 64'h3);
        for (i = 0; i < (cw ? 36 : 18); i++) begin
            if (cw) begin
                exp = {~i[0], i[0]};
            end else begin
                exp = (i < 16) ? {pp[i/2] ^ inv, pn[i/2] ^ inv} : 2'b00;
            end
            check({cap_p[s0+i][0], cap_n[s0+i][0]}, exp);
        end
    endtask

    initial begin
        repeat (50000) @(posedge clk_in);
        errors++;
        stop_test();
    end

    initial begin
        clk_in = 1'b0;
        rstn_in = 1'b0;
        tx_en_in = 1'b0;
        errors = 0;
        samples_checked = 0;
        repeat (3) @(negedge clk_in);
        rstn_in = 1'b1;
        // invert on, pll on, divider 2, length code 1
        wr(BFM_ADDR_CONTROL, 64'h0000_0000_0000_0C11, 14);
        rd_chk(BFM_ADDR_CONTROL, 14, 64'h0000_0000_0000_0C11);
        check(64'(pll_en), 64'h1);
        wr(BFM_ADDR_P_PATTERN, 64'h0000_0000_0000_0096, 8);
        wr(BFM_ADDR_N_PATTERN, 64'h0000_0000_0000_0069, 8);
        wr(5'h01, 64'h0000_0000_0000_0003, 22);
        rd_chk(BFM_ADDR_P_PATTERN, 8, 64'h0000_0000_0000_0096);
        fire(8'h96, 8'h69, 1'b0, 1'b0);
        rd_chk(BFM_ADDR_STATUS, 4, 64'h0000_0000_0000_0004);
        fire(8'h96, 8'h69, 1'b1, 1'b0);
        rd_chk(BFM_ADDR_STATUS, 4, 64'h0000_0000_0000_0002);
        fire(8'h96, 8'h69, 1'b0, 1'b0);
        wr(BFM_ADDR_CONTROL, 64'h0000_0000_0000_0411, 14);
        fire(8'h96, 8'h69, 1'b0, 1'b0);
        fire(8'h96, 8'h69, 1'b0, 1'b0);
        // cw on, divider 1, length code 0
        wr(BFM_ADDR_CONTROL, 64'h0000_0000_0000_1408, 14);
        wr(BFM_ADDR_P_PATTERN, 64'h0000_0000_0000_00FF, 8);
        rd_chk(BFM_ADDR_P_PATTERN, 8, 64'h0000_0000_0000_0096);
        fire(8'h00, 8'h00, 1'b0, 1'b1);
        stop_test();
    end
endmodule
